// ===== verilog/ptm_pkg.sv
package ptm_pkg;

  // register byte offsets
  localparam logic [7:0] REG_RELAY_SEL   = 8'h00;
  localparam logic [7:0] REG_COLL_SEL    = 8'h04;
  localparam logic [7:0] REG_METER_SRC   = 8'h08;
  localparam logic [7:0] REG_METER_CAL   = 8'h0C;
  localparam logic [7:0] REG_METER_RANGE = 8'h10;
  localparam logic [7:0] REG_FREQ_REACH  = 8'h14;
  localparam logic [7:0] REG_INPUT_SEL   = 8'h18;
  localparam logic [7:0] REG_LATENT_FREQ = 8'h1C;
  localparam logic [7:0] REG_SET_TARGET  = 8'h20;
  localparam logic [7:0] REG_DES_TARGET  = 8'h24;
  localparam logic [7:0] REG_MAX_FREQ    = 8'h28;
  localparam logic [7:0] REG_RATED_CURR  = 8'h2C;
  localparam logic [7:0] REG_OVLD_LEVEL  = 8'h30;
  localparam logic [7:0] REG_STATUS      = 8'h34;
  localparam logic [7:0] REG_COUNT       = 8'h38;
  localparam logic [7:0] REG_PULSE_FREQ  = 8'h3C;
  localparam logic [7:0] REG_METER_OUT   = 8'h40;

  // reset values (frequencies in 0.01 Hz)
  localparam logic [7:0]  RST_RELAY_SEL   = 8'h01;
  localparam logic [7:0]  RST_COLL_SEL    = 8'h04;
  localparam logic [7:0]  RST_METER_SRC   = 8'h00;
  localparam logic [7:0]  RST_METER_CAL   = 8'h64;
  localparam logic [7:0]  RST_METER_RANGE = 8'h00;
  localparam logic [15:0] RST_FREQ_REACH  = 16'h01F4;
  localparam logic [15:0] RST_MAX_FREQ    = 16'h1388;
  localparam logic [15:0] RST_RATED_CURR  = 16'h03E8;
  localparam logic [15:0] RST_OVLD_LEVEL  = 16'h04B0;

  // selector limits
  localparam logic [7:0] RELAY_SEL_MAX = 8'h0C;
  localparam logic [7:0] COLL_SEL_MAX  = 8'h0D;
  localparam logic [7:0] CAL_MAX       = 8'hC8;

  // output function codes
  localparam logic [7:0] OF_FAULT   = 8'h01;
  localparam logic [7:0] OF_LATENT  = 8'h02;
  localparam logic [7:0] OF_COAST   = 8'h03;
  localparam logic [7:0] OF_RUN     = 8'h04;
  localparam logic [7:0] OF_DCBRAKE = 8'h05;
  localparam logic [7:0] OF_ACC2    = 8'h06;
  localparam logic [7:0] OF_SETCNT  = 8'h07;
  localparam logic [7:0] OF_DESCNT  = 8'h08;
  localparam logic [7:0] OF_OVLD    = 8'h09;
  localparam logic [7:0] OF_FREACH  = 8'h0B;

  // input function codes
  localparam logic [7:0] IF_SINGLE_CH = 8'h14;
  localparam logic [7:0] IF_COUNT     = 8'h15;
  localparam logic [7:0] IF_CLEAR     = 8'h16;
  localparam logic [7:0] IF_PULSE_FRQ = 8'h17;

  // meter span in output codes: 4 mA of 20 mA is one fifth
  localparam logic [15:0] METER_FULL   = 16'hFFFF;
  localparam logic [15:0] METER_OFFSET = 16'h3333;

  // pulse frequency gate: one second at 25 MHz
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned GATE_S       = 1;
  localparam int unsigned GATE_CYCLES  = CLK_HZ * GATE_S;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // drive status inputs
  typedef struct packed {
    logic        fault;
    logic        undervolt;
    logic        coast;
    logic        running;
    logic        dc_brake;
    logic        acc2_active;
    logic [15:0] run_freq;
    logic [15:0] out_freq;
    logic [15:0] out_curr;
  } ptm_drive_s;

endpackage

// ===== verilog/ptm_terminal_mapper.sv
`timescale 1ns/1ps
// Summary of operation
// - code 20 selects single analog channel
// - code 21 pulses increment the counter
// - code 22 active clears the counter
// - code 23 pulse frequency, first input only
// - relay selector 0-12, collector 0-13
// - asserted output closes contact, collector on
// - code 1 any fault except undervoltage
// - code 2 frequency above latent threshold
// - code 3 coast stop input active
// - code 4 drive running
// - code 5 DC braking applied
// - code 6 second ramp set in use
// - codes 7/8 count reaches targets
// - code 9 current at overload level
// - code 11 frequency reaches user threshold
// - meter source frequency or current
// - meter range 0-20 or 4-20 mA
// - meter calibration percent 0-200
module ptm_terminal_mapper #(
  parameter int unsigned NUM_IN      = 8,
  parameter int unsigned GATE_CYCLES = ptm_pkg::GATE_CYCLES
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // drive status from the same clock domain
  input  wire ptm_pkg::ptm_drive_s drive,
  // programmable input terminals, pins
  input  wire logic [NUM_IN-1:0] input_pins,
  // terminal outputs
  output logic                   relay_normally_open_contact,
  output logic                   relay_normally_closed_contact,
  output logic                   collector_on,
  output logic                   single_channel_mode,
  output logic                   pulse_speed_mode,
  output logic [15:0]            pulse_freq,
  output logic [15:0]            meter_level
);

  // configuration registers
  logic [7:0]  relay_output_function_select;
  logic [7:0]  collector_output_function_select;
  logic [7:0]  meter_output_source_select;
  logic [7:0]  meter_output_calibration;
  logic [7:0]  meter_output_range_select;
  logic [15:0] frequency_reach_threshold;
  logic [7:0]  first_input_function_select;
  logic [15:0] latent_frequency_threshold;
  logic [15:0] set_count_target;
  logic [15:0] designated_count_target;
  logic [15:0] maximum_frequency_limit;
  logic [15:0] rated_current;
  logic [15:0] overload_level;

  // bus handshake state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // input synchronisers and counter
  logic [NUM_IN-1:0] in_meta;
  logic [NUM_IN-1:0] in_sync;
  logic [NUM_IN-1:0] in_prev;
  logic [15:0]       count;
  logic [31:0]       gate_cnt;
  logic [15:0]       edge_cnt;

  // derived terminal conditions
  logic [15:0] cond;
  logic fn_active [2];
  logic [15:0] meter_src;
  logic [31:0] meter_cal;
  logic [39:0] meter_scaled;
  logic [15:0] meter_span;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ptm_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known(aw_addr) ? ptm_pkg::RESP_OKAY
                                          : ptm_pkg::RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable offsets; status words are read only
  function automatic logic wr_known(input logic [7:0] a);
    wr_known = (a <= ptm_pkg::REG_OVLD_LEVEL) && (a[1:0] == 2'b00);
  endfunction

  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // register stores; out-of-range selector writes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_output_function_select     <= ptm_pkg::RST_RELAY_SEL;
      collector_output_function_select <= ptm_pkg::RST_COLL_SEL;
      meter_output_source_select       <= ptm_pkg::RST_METER_SRC;
      meter_output_calibration         <= ptm_pkg::RST_METER_CAL;
      meter_output_range_select        <= ptm_pkg::RST_METER_RANGE;
      frequency_reach_threshold        <= ptm_pkg::RST_FREQ_REACH;
      first_input_function_select      <= 8'h00;
      latent_frequency_threshold       <= 16'h0000;
      set_count_target                 <= 16'h0000;
      designated_count_target          <= 16'h0000;
      maximum_frequency_limit          <= ptm_pkg::RST_MAX_FREQ;
      rated_current                    <= ptm_pkg::RST_RATED_CURR;
      overload_level                   <= ptm_pkg::RST_OVLD_LEVEL;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        ptm_pkg::REG_RELAY_SEL:
          if (w_data[7:0] <= ptm_pkg::RELAY_SEL_MAX)
            relay_output_function_select <= w_data[7:0];
        ptm_pkg::REG_COLL_SEL:
          if (w_data[7:0] <= ptm_pkg::COLL_SEL_MAX)
            collector_output_function_select <= w_data[7:0];
        ptm_pkg::REG_METER_SRC:
          if (w_data[7:1] == 7'h00)
            meter_output_source_select <= w_data[7:0];
        ptm_pkg::REG_METER_CAL:
          if (w_data[7:0] <= ptm_pkg::CAL_MAX)
            meter_output_calibration <= w_data[7:0];
        ptm_pkg::REG_METER_RANGE:
          if (w_data[7:1] == 7'h00)
            meter_output_range_select <= w_data[7:0];
        ptm_pkg::REG_FREQ_REACH:  frequency_reach_threshold <= w_data[15:0];
        ptm_pkg::REG_INPUT_SEL:   first_input_function_select <= w_data[7:0];
        ptm_pkg::REG_LATENT_FREQ: latent_frequency_threshold <= w_data[15:0];
        ptm_pkg::REG_SET_TARGET:  set_count_target <= w_data[15:0];
        ptm_pkg::REG_DES_TARGET:  designated_count_target <= w_data[15:0];
        ptm_pkg::REG_MAX_FREQ:    maximum_frequency_limit <= w_data[15:0];
        ptm_pkg::REG_RATED_CURR:  rated_current <= w_data[15:0];
        ptm_pkg::REG_OVLD_LEVEL:  overload_level <= w_data[15:0];
        default: ;
      endcase
    end
  end

  // read channel: one cycle to accept, data the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ptm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ptm_pkg::RESP_OKAY;
        case (s_axi_araddr)
          ptm_pkg::REG_RELAY_SEL:
            s_axi_rdata <= {24'h000000, relay_output_function_select};
          ptm_pkg::REG_COLL_SEL:
            s_axi_rdata <= {24'h000000, collector_output_function_select};
          ptm_pkg::REG_METER_SRC:
            s_axi_rdata <= {24'h000000, meter_output_source_select};
          ptm_pkg::REG_METER_CAL:
            s_axi_rdata <= {24'h000000, meter_output_calibration};
          ptm_pkg::REG_METER_RANGE:
            s_axi_rdata <= {24'h000000, meter_output_range_select};
          ptm_pkg::REG_FREQ_REACH:
            s_axi_rdata <= {16'h0000, frequency_reach_threshold};
          ptm_pkg::REG_INPUT_SEL:
            s_axi_rdata <= {24'h000000, first_input_function_select};
          ptm_pkg::REG_LATENT_FREQ:
            s_axi_rdata <= {16'h0000, latent_frequency_threshold};
          ptm_pkg::REG_SET_TARGET:
            s_axi_rdata <= {16'h0000, set_count_target};
          ptm_pkg::REG_DES_TARGET:
            s_axi_rdata <= {16'h0000, designated_count_target};
          ptm_pkg::REG_MAX_FREQ:
            s_axi_rdata <= {16'h0000, maximum_frequency_limit};
          ptm_pkg::REG_RATED_CURR:
            s_axi_rdata <= {16'h0000, rated_current};
          ptm_pkg::REG_OVLD_LEVEL:
            s_axi_rdata <= {16'h0000, overload_level};
          ptm_pkg::REG_STATUS:
            s_axi_rdata <= {26'h0000000, pulse_speed_mode,
                            single_channel_mode, collector_on,
                            relay_normally_open_contact, fn_active[1],
                            fn_active[0]};
          ptm_pkg::REG_COUNT:
            s_axi_rdata <= {16'h0000, count};
          ptm_pkg::REG_PULSE_FREQ:
            s_axi_rdata <= {16'h0000, pulse_freq};
          ptm_pkg::REG_METER_OUT:
            s_axi_rdata <= {16'h0000, meter_level};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ptm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // two-flop synchroniser, then a third stage for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= '0;
      in_sync <= '0;
      in_prev <= '0;
    end else begin
      in_meta <= input_pins;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  // only the first input has a selector here; the others are not mapped
  logic fn_count;
  logic fn_clear;
  logic fn_pulse;
  logic cnt_edge;
  assign fn_count = first_input_function_select == ptm_pkg::IF_COUNT;
  assign fn_clear = first_input_function_select == ptm_pkg::IF_CLEAR;
  assign fn_pulse = first_input_function_select == ptm_pkg::IF_PULSE_FRQ;
  assign cnt_edge = in_sync[0] && !in_prev[0];

  // count events; no filter, so pulses above 300 Hz are the source's duty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
    end else if (fn_clear && in_sync[0]) begin
      count <= 16'h0000;
    end else if (fn_count && cnt_edge && count != 16'hFFFF) begin
      count <= count + 16'h0001;
    end
  end

  // pulse frequency measured over a one-second gate, in Hz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt   <= 32'h0000_0000;
      edge_cnt   <= 16'h0000;
      pulse_freq <= 16'h0000;
    end else if (!fn_pulse) begin
      gate_cnt <= 32'h0000_0000;
      edge_cnt <= 16'h0000;
    end else if (gate_cnt == 32'(GATE_CYCLES - 1)) begin
      gate_cnt   <= 32'h0000_0000;
      pulse_freq <= edge_cnt + {15'h0000, cnt_edge};
      edge_cnt   <= 16'h0000;
    end else begin
      gate_cnt <= gate_cnt + 32'h0000_0001;
      if (cnt_edge && edge_cnt != 16'hFFFF)
        edge_cnt <= edge_cnt + 16'h0001;
    end
  end

  // mode flags for the speed reference selector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_channel_mode <= 1'b0;
      pulse_speed_mode    <= 1'b0;
    end else begin
      single_channel_mode <= first_input_function_select
                             == ptm_pkg::IF_SINGLE_CH && in_sync[0];
      pulse_speed_mode    <= fn_pulse;
    end
  end

  // each condition once; a selector picks its bit, unused codes read 0
  always_comb begin
    cond     = 16'h0000;
    cond[1]  = drive.fault && !drive.undervolt;
    cond[2]  = drive.run_freq > latent_frequency_threshold;
    cond[3]  = drive.coast;
    cond[4]  = drive.running;
    cond[5]  = drive.dc_brake;
    cond[6]  = drive.acc2_active;
    cond[7]  = fn_count && count >= set_count_target;
    cond[8]  = fn_count && count >= designated_count_target;
    cond[9]  = drive.out_curr >= overload_level;
    cond[11] = drive.out_freq >= frequency_reach_threshold;
  end

  // selectors are range-checked on write, so the low nibble suffices
  assign fn_active[0] = cond[relay_output_function_select[3:0]];
  assign fn_active[1] = cond[collector_output_function_select[3:0]];

  // terminal drive: contacts are complementary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_normally_open_contact   <= 1'b0;
      relay_normally_closed_contact <= 1'b1;
      collector_on                  <= 1'b0;
    end else begin
      relay_normally_open_contact   <= fn_active[0];
      relay_normally_closed_contact <= !fn_active[0];
      collector_on                  <= fn_active[1];
    end
  end

  // meter: normalise source to full scale, calibrate, then offset
  always_comb begin
    meter_src = meter_output_source_select[0] ? drive.out_curr
                                              : drive.out_freq;
    meter_cal = '0;
    if (meter_output_source_select[0]) begin
      if (rated_current != 16'h0000)
        meter_cal = ({16'h0000, meter_src} * 32'h0000_FFFF)
                    / {16'h0000, rated_current};
    end else if (maximum_frequency_limit != 16'h0000) begin
      meter_cal = ({16'h0000, meter_src} * 32'h0000_FFFF)
                  / {16'h0000, maximum_frequency_limit};
    end
    // calibration percent; saturates at full scale
    meter_scaled = ({8'h00, meter_cal} * {32'h0, meter_output_calibration})
                   / 40'h64;
    if (meter_scaled > {24'h000000, ptm_pkg::METER_FULL})
      meter_scaled = {24'h000000, ptm_pkg::METER_FULL};
    meter_span = ptm_pkg::METER_FULL - ptm_pkg::METER_OFFSET;
  end

  // 4-20 mA lifts zero to one fifth of full scale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meter_level <= 16'h0000;
    end else if (meter_output_range_select[0]) begin
      meter_level <= ptm_pkg::METER_OFFSET
        + 16'((meter_scaled * {24'h000000, meter_span})
              / {24'h000000, ptm_pkg::METER_FULL});
    end else begin
      meter_level <= meter_scaled[15:0];
    end
  end

endmodule

// ===== test/ptm_pulse_src.sv
`timescale 1ns/1ps
// far-side pulse source and terminal level driver on the first input
module ptm_pulse_src #(
  parameter int HALF = 10
) (
  // clock
  input  wire logic       aclk,
  // control from the bench
  input  wire logic       go,
  input  wire logic [7:0] num,
  input  wire logic       lvl,
  // terminal side
  output logic            pin,
  output logic            busy = 1'b0
);
  logic p = 1'b0;

  // spacing scaled down to keep runs short; only edges are counted
  always @(posedge aclk) begin
    if (go) begin
      busy <= 1'b1;
      repeat (num) begin
        p <= 1'b1;
        repeat (HALF) @(posedge aclk);
        p <= 1'b0;
        repeat (HALF) @(posedge aclk);
      end
      busy <= 1'b0;
    end
  end

  // plain level, low between pulses
  assign pin = p | lvl;
endmodule

// ===== test/ptm_terminal_mapper_assertions.sv
`timescale 1ns/1ps
module ptm_terminal_mapper_assertions (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // write side of the register bus
  input wire logic [7:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  // status and terminals
  input wire ptm_pkg::ptm_drive_s drive,
  input wire logic                relay_normally_open_contact,
  input wire logic                relay_normally_closed_contact,
  input wire logic                collector_on
);
  logic [7:0] aw_q, w_q, rsel, csel;
  logic       pend;
  wire logic  rly = relay_normally_open_contact;

  // capture the write address and data as they are taken
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
  end

  // selector shadow; checks pause while a write is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 1'b0;
      rsel <= 8'h01;
      csel <= 8'h04;
    end else if (s_axi_bvalid && s_axi_bready) begin
      pend <= 1'b0;
      if (aw_q == ptm_pkg::REG_RELAY_SEL && w_q <= 8'h0C) rsel <= w_q;
      if (aw_q == ptm_pkg::REG_COLL_SEL && w_q <= 8'h0D) csel <= w_q;
    end else if (s_axi_awvalid || s_axi_wvalid) begin
      pend <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_NC_COMPL: assert property (
    relay_normally_closed_contact != rly)
    else $error("relay contacts not complementary");
  AST_FAULT: assert property (
    !pend && rsel == 8'h01 |=>
      rly == ($past(drive.fault) && !$past(drive.undervolt)))
    else $error("fault indication wrong");
  AST_RESERVED: assert property (
    !pend && (rsel == 8'h00 || rsel == 8'h0A || rsel == 8'h0C) |=> !rly)
    else $error("idle relay code asserted");
  AST_COAST: assert property (
    !pend && rsel == 8'h03 |=> rly == $past(drive.coast))
    else $error("coast indication wrong");
  AST_ACC2: assert property (
    !pend && rsel == 8'h06 |=> rly == $past(drive.acc2_active))
    else $error("ramp set indication wrong");
  AST_RUN: assert property (
    !pend && csel == 8'h04 |=> collector_on == $past(drive.running))
    else $error("run indication wrong");
  AST_BRAKE: assert property (
    !pend && csel == 8'h05 |=> collector_on == $past(drive.dc_brake))
    else $error("brake indication wrong");
  AST_AW_PULSE: assert property (
    s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");

  // main scenarios reached
  cover property (!pend && rsel == 8'h01 && rly);
  cover property (!pend && csel == 8'h04 && collector_on);
  cover property (s_axi_bvalid && s_axi_bready && pend);
endmodule

bind ptm_terminal_mapper ptm_terminal_mapper_assertions u_chk (.*);

// ===== test/programmable_terminal_mapper_tb.sv
`timescale 1ns/1ps
module programmable_terminal_mapper_tb;
  localparam logic [1:0] OK  = ptm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ptm_pkg::RESP_SLVERR;
  // corners: equal to and just off each threshold
  localparam ptm_pkg::ptm_drive_s C0 = {6'h20, 48'h1000_01F4_04B0};
  localparam ptm_pkg::ptm_drive_s C1 = {6'h30, 48'h1001_01F3_04AF};
  logic                aclk, aresetn, go, lvl, busy, pin0;
  logic [7:0]          s_axi_awaddr, s_axi_araddr, num, rc;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic                s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                s_axi_rvalid, single_channel_mode;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  ptm_pkg::ptm_drive_s drive, d;
  logic [6:0]          pins_hi;
  wire logic [7:0]     input_pins = {pins_hi, pin0};
  logic                relay_normally_open_contact, collector_on;
  logic                relay_normally_closed_contact, pulse_speed_mode;
  logic [15:0]         pulse_freq, meter_level;
  int                  fail_count, samples_checked, c, k;

  ptm_terminal_mapper #(.NUM_IN(8), .GATE_CYCLES(100))
    u_ptm_terminal_mapper (.*);
  ptm_pulse_src #(.HALF(10)) u_ptm_pulse_src (.aclk, .go, .num, .lvl,
                                              .pin(pin0), .busy);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input int v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(v);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input int e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, 32'(e));
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // start a pulse train, optionally waiting for it to end
  task automatic pulses(input logic [7:0] n, input logic w);
    num <= n;
    go <= 1'b1;
    step(1);
    go <= 1'b0;
    step(1);
    while (busy && w) @(posedge aclk);
    step(4);
  endtask

  task automatic meter(input int s, r, cl, input ptm_pkg::ptm_drive_s v,
                       input logic [15:0] e);
    wr(ptm_pkg::REG_METER_SRC, s, OK);
    wr(ptm_pkg::REG_METER_RANGE, r, OK);
    wr(ptm_pkg::REG_METER_CAL, cl, OK);
    drive <= v;
    step(4);
    chk(32'(meter_level), 32'(e));
  endtask

  // expected terminal level; latent threshold written as 1000h
  function automatic logic fexp(input logic [7:0] f,
                                input ptm_pkg::ptm_drive_s v);
    case (f)
      8'h01: fexp = v.fault && !v.undervolt;
      8'h02: fexp = v.run_freq > 16'h1000;
      8'h03: fexp = v.coast;
      8'h04: fexp = v.running;
      8'h05: fexp = v.dc_brake;
      8'h06: fexp = v.acc2_active;
      8'h09: fexp = v.out_curr >= ptm_pkg::RST_OVLD_LEVEL;
      8'h0B: fexp = v.out_freq >= 16'h01F4;
      default: fexp = 1'b0; // counts idle while not counting
    endcase
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well past the expected few thousand cycles
  initial begin
    step(20000);
    fail_count++;
    conclude();
  end

  initial begin
    {aresetn, go, lvl, num, pins_hi, drive} = '0;
    // answers are always taken at once, so both readies stay high
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_rready} = 4'h3;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(48018));
    step(16);
    aresetn <= 1'b1;
    step(1);
    rd(ptm_pkg::REG_RELAY_SEL, 1, OK);
    rd(ptm_pkg::REG_COLL_SEL, 4, OK);
    rd(ptm_pkg::REG_METER_SRC, 0, OK);
    rd(ptm_pkg::REG_METER_CAL, 100, OK);
    rd(ptm_pkg::REG_METER_RANGE, 0, OK);
    rd(ptm_pkg::REG_FREQ_REACH, 500, OK);
    wr(ptm_pkg::REG_RELAY_SEL, 13, OK);
    rd(ptm_pkg::REG_RELAY_SEL, 1, OK);
    wr(ptm_pkg::REG_COLL_SEL, 14, OK);
    rd(ptm_pkg::REG_COLL_SEL, 4, OK);
    wr(ptm_pkg::REG_METER_CAL, 201, OK);
    rd(ptm_pkg::REG_METER_CAL, 100, OK);
    wr(ptm_pkg::REG_STATUS, 1, ERR);
    rd(8'h7C, 0, ERR);
    wr(ptm_pkg::REG_LATENT_FREQ, 32'h1000, OK);
    // every selector code on both outputs; relay refuses 13
    for (c = 0; c < 14; c++) begin
      rc = (c < 13) ? 8'(c) : 8'h0C;
      wr(ptm_pkg::REG_RELAY_SEL, c, OK);
      wr(ptm_pkg::REG_COLL_SEL, c, OK);
      for (k = 0; k < 5; k++) begin
        d = (k == 0) ? C0 : (k == 1) ? C1 : 54'({$urandom, $urandom});
        drive <= d;
        pins_hi <= 7'($urandom);
        step(2);
        chk(32'(relay_normally_open_contact), 32'(fexp(rc, d)));
        chk(32'(relay_normally_closed_contact), 32'(!fexp(rc, d)));
        chk(32'(collector_on), 32'(fexp(8'(c), d)));
      end
    end
    // counting: just under, then at the set target, then at the designated target
    wr(ptm_pkg::REG_SET_TARGET, 3, OK);
    wr(ptm_pkg::REG_DES_TARGET, 5, OK);
    wr(ptm_pkg::REG_RELAY_SEL, 7, OK);
    wr(ptm_pkg::REG_COLL_SEL, 8, OK);
    wr(ptm_pkg::REG_INPUT_SEL, 21, OK);
    pulses(2, 1'b1);
    chk(32'(relay_normally_open_contact), 0);
    pulses(1, 1'b1);
    chk(32'(relay_normally_open_contact), 1);
    chk(32'(collector_on), 0);
    rd(ptm_pkg::REG_COUNT, 3, OK);
    pulses(2, 1'b1);
    chk(32'(collector_on), 1);
    rd(ptm_pkg::REG_COUNT, 5, OK);
    wr(ptm_pkg::REG_INPUT_SEL, 22, OK);
    lvl <= 1'b1;
    step(6);
    rd(ptm_pkg::REG_COUNT, 0, OK);
    wr(ptm_pkg::REG_INPUT_SEL, 20, OK);
    step(4);
    chk(32'(single_channel_mode), 1);
    lvl <= 1'b0;
    step(5);
    chk(32'(single_channel_mode), 0);
    // 20-cycle period against a 100-cycle gate gives five
    wr(ptm_pkg::REG_INPUT_SEL, 23, OK);
    pulses(60, 1'b0);
    chk(32'(pulse_speed_mode), 1);
    step(600);
    chk(32'(pulse_freq), 5);
    pulses(0, 1'b1);
    meter(0, 0, 100, {22'h0, 16'h1388, 16'h0}, 16'hFFFF);
    meter(0, 1, 100, '0, 16'h3333);
    meter(1, 0, 100, {38'h0, 16'h03E8}, 16'hFFFF);
    meter(1, 0, 0, {38'h0, 16'h03E8}, 16'h0000);
    conclude();
  end
endmodule
